// ### shared/sece_pkg.sv
package sece_pkg;
   // instruction opcodes
   localparam logic [7:0]  OPC_WR_EN  = 8'h06;
   localparam logic [7:0]  OPC_WR_DIS = 8'h04;
   localparam logic [7:0]  OPC_ST_RD  = 8'h05;
   localparam logic [7:0]  OPC_ST_WR  = 8'h01;
   localparam logic [7:0]  OPC_READ  = 8'h03;
   localparam logic [7:0]  OPC_WRITE = 8'h02;
   // array geometry and protected regions
   localparam int          ADDR_W     = 15;
   localparam int          MEM_DEPTH  = 32768;
   localparam logic [6:0]  PAGE_BYTES = 7'h40;
   localparam logic [14:0] ADDR_TOP   = 15'h7FFF;
   localparam logic [14:0] PROT_QTR   = 15'h6000;
   localparam logic [14:0] PROT_HALF  = 15'h4000;
   // status bit positions
   localparam int          ST_PROT_EN = 7;
   localparam int          ST_BP_HI   = 3;
   localparam int          ST_BP_LO   = 2;
   localparam int          ST_WEL     = 1;
   localparam int          ST_BUSY    = 0;
   localparam logic [6:0]  STAT_ONES  = 7'h7F;
   // values after reset
   localparam logic        WEL_RST    = 1'b0;
   localparam logic        PROT_EN_RST = 1'b0;
   localparam logic [1:0]  BP_RST     = 2'h0;
   // byte phase within a frame
   localparam logic [1:0]  PH_OPC     = 2'h0;
   localparam logic [1:0]  PH_AHI     = 2'h1;
   localparam logic [1:0]  PH_ALO     = 2'h2;
   localparam logic [1:0]  PH_DATA    = 2'h3;
   // write cycle timing
   localparam int          CLK_HZ        = 100_000_000;
   localparam int          WRITE_CYCLE_US = 10_000;
   localparam int          PROG_CYCLES_DFLT = WRITE_CYCLE_US * (CLK_HZ / 1_000_000);
   localparam int          TIMER_W       = 20;
   localparam logic [19:0] TIMER_RST     = 20'h0_0000;

   typedef enum logic [1:0] {PG_IDLE, PG_COPY, PG_WAIT} sece_prog_t;
endpackage

// ### rtl/sece_engine.sv
`timescale 1ns/10ps
// Notes on behaviour
// - status read shifts out full status byte
// - status write changes only protect and block bits
// - during status programming: busy true, others ones
// - serial input sampled on rising serial clock
// - read: opcode then two address bytes
// - read ignores top address bit
// - read data driven on falling serial clock
// - address increments after each byte out
// - read past top address wraps to zero
// - raising select ends read and output
// - write enable latch set at select rise
// - write: opcode, address, top bit ignored
// - write bytes latched, address then increments
// - at most 64 bytes per write sequence
// - cycle starts only on whole-byte select rise
// - busy flag one while programming, else zero
// - write enable cleared when cycle completes
// - eight-bit opcodes for latch and write
// - block bits choose protected top region
// - protect pin plus enable blocks status writes
// - status layout; bits 6:4 zero normally
module sece_engine
   import sece_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic sck,
   input  wire logic cs_n,
   input  wire logic si,
   input  wire logic wp_n,
   output logic      so,
   output logic      so_oe,
   output logic      busy_flag
);

   function automatic logic sece_prot(input logic [1:0] bp, input logic [14:0] a);
      case (bp)
         2'h1:    sece_prot = (a >= PROT_QTR);
         2'h2:    sece_prot = (a >= PROT_HALF);
         2'h3:    sece_prot = 1'b1;
         default: sece_prot = 1'b0;
      endcase
   endfunction

   // array lives in the system domain; the link only reads it while idle
   logic [7:0]  mem [0:MEM_DEPTH-1];
   logic [7:0]  page [0:63];

   // link side, clocked by sck
   logic        frame_rst;
   logic        frame_open_reg;
   logic [2:0]  bit_cnt_reg;
   logic [1:0]  phase_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  ahi_reg;
   logic [14:0] addr_reg;
   logic [14:0] wbase_reg;
   logic [6:0]  wcnt_reg;
   logic [7:0]  sdata_reg;
   logic        tog_reg;
   logic [7:0]  stat_s1_reg;
   logic [7:0]  stat_s2_reg;
   logic [7:0]  stat_word_reg;
   logic [2:0]  bit_now;
   logic [1:0]  ph_now;
   logic [7:0]  rx_byte;
   logic        byte_end;
   logic        data_inc;
   logic [7:0]  out_byte;
   logic        out_active;

   // the frame flag and the so/so_oe outputs are the only state that select clears; the rest is kept
   // so the system domain can inspect the finished frame after select rises
   assign frame_rst = rst | cs_n;
   assign bit_now   = frame_open_reg ? bit_cnt_reg : 3'h0;
   assign ph_now    = frame_open_reg ? phase_reg : PH_OPC;
   assign rx_byte   = {shift_reg[6:0], si};
   assign byte_end  = (bit_now == 3'h7);
   assign data_inc  = byte_end && (ph_now == PH_DATA)
                      && ((cmd_reg == OPC_READ) || (cmd_reg == OPC_WRITE));
   assign out_byte  = (cmd_reg == OPC_ST_RD) ? stat_s2_reg : mem[addr_reg];
   // array reads are refused while busy, status reads are not: the array may be changing under us
   assign out_active = ((cmd_reg == OPC_ST_RD) && (phase_reg != PH_OPC))
                       || ((cmd_reg == OPC_READ) && (phase_reg == PH_DATA)
                           && !stat_s2_reg[ST_BUSY]);

   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         frame_open_reg <= 1'b0;
      end else begin
         frame_open_reg <= 1'b1;
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         stat_s1_reg <= 8'h00;
         stat_s2_reg <= 8'h00;
      end else begin
         stat_s1_reg <= stat_word_reg;
         stat_s2_reg <= stat_s1_reg;
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         bit_cnt_reg <= 3'h0;
         phase_reg   <= PH_OPC;
         shift_reg   <= 8'h00;
         tog_reg     <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_now + 3'h1;
         shift_reg   <= rx_byte;
         if (!frame_open_reg) begin
            tog_reg <= ~tog_reg;
         end
         if (byte_end && (ph_now != PH_DATA)) begin
            phase_reg <= ph_now + 2'h1;
         end else begin
            phase_reg <= ph_now;
         end
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         cmd_reg   <= 8'h00;
         ahi_reg   <= 8'h00;
         addr_reg  <= 15'h0000;
         wbase_reg <= 15'h0000;
         wcnt_reg  <= 7'h00;
         sdata_reg <= 8'h00;
      end else if (byte_end) begin
         case (ph_now)
            PH_OPC: begin
               cmd_reg <= rx_byte;
            end
            PH_AHI: begin
               ahi_reg   <= rx_byte;
               sdata_reg <= rx_byte;
            end
            PH_ALO: begin
               addr_reg <= {ahi_reg[6:0], rx_byte};
               if (cmd_reg == OPC_WRITE) begin
                  wbase_reg <= {ahi_reg[6:0], rx_byte};
                  wcnt_reg  <= 7'h00;
               end
            end
            PH_DATA: begin
               if (data_inc) begin
                  addr_reg <= addr_reg + 15'h0001;
               end
               if ((cmd_reg == OPC_WRITE) && (wcnt_reg < PAGE_BYTES)) begin
                  wcnt_reg <= wcnt_reg + 7'h01;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sck) begin
      if (byte_end && (ph_now == PH_DATA) && (cmd_reg == OPC_WRITE)
          && (wcnt_reg < PAGE_BYTES)) begin
         page[wcnt_reg[5:0]] <= rx_byte;
      end
   end

   always_ff @(negedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         so    <= 1'b0;
         so_oe <= 1'b0;
      end else begin
         so    <= out_byte[3'h7 - bit_cnt_reg];
         so_oe <= frame_open_reg && out_active;
      end
   end

   // system side, clocked by clk
   sece_prog_t        state_reg;
   logic              cs_s1_reg;
   logic              cs_s2_reg;
   logic              cs_s3_reg;
   logic              wp_s1_reg;
   logic              wp_s2_reg;
   logic              tog_s1_reg;
   logic              tog_s2_reg;
   logic              tog_seen_reg;
   logic              wel_reg;
   logic              prot_en_reg;
   logic [1:0]        bp_reg;
   logic              busy_reg;
   logic              stprog_reg;
   logic [TIMER_W-1:0] timer_reg;
   logic [6:0]        idx_reg;
   logic              end_frame;
   logic              cmd_ok;
   logic              hw_prot;
   logic              do_wr_en;
   logic              do_wr_dis;
   logic              do_st_wr;
   logic              do_write;
   logic              prog_done;
   logic [14:0]       mem_addr;
   logic              mem_we;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s1_reg    <= 1'b1;
         cs_s2_reg    <= 1'b1;
         cs_s3_reg    <= 1'b1;
         wp_s1_reg    <= 1'b1;
         wp_s2_reg    <= 1'b1;
         tog_s1_reg   <= 1'b0;
         tog_s2_reg   <= 1'b0;
         tog_seen_reg <= 1'b0;
      end else begin
         cs_s1_reg  <= cs_n;
         cs_s2_reg  <= cs_s1_reg;
         cs_s3_reg  <= cs_s2_reg;
         wp_s1_reg  <= wp_n;
         wp_s2_reg  <= wp_s1_reg;
         tog_s1_reg <= tog_reg;
         tog_s2_reg <= tog_s1_reg;
         if (cs_s2_reg && !cs_s3_reg) begin
            tog_seen_reg <= tog_s2_reg;
         end
      end
   end

   // a frame counts only if it saw a clock edge; the link registers are
   // quiet once select is high, so reading them here on the synced rise is safe
   assign end_frame = cs_s2_reg && !cs_s3_reg && (tog_s2_reg != tog_seen_reg);
   assign cmd_ok    = end_frame && (bit_cnt_reg == 3'h0) && !busy_reg;
   assign hw_prot   = !wp_s2_reg && prot_en_reg;
   assign do_wr_en  = cmd_ok && (cmd_reg == OPC_WR_EN) && (phase_reg != PH_OPC);
   assign do_wr_dis = cmd_ok && (cmd_reg == OPC_WR_DIS) && (phase_reg != PH_OPC);
   assign do_st_wr  = cmd_ok && (cmd_reg == OPC_ST_WR) && (phase_reg == PH_ALO)
                      && wel_reg && !hw_prot;
   assign do_write  = cmd_ok && (cmd_reg == OPC_WRITE) && (phase_reg == PH_DATA)
                      && (wcnt_reg != 7'h00) && wel_reg;
   assign prog_done = (state_reg == PG_WAIT) && (timer_reg == TIMER_RST);
   assign mem_addr  = wbase_reg + {8'h00, idx_reg};
   assign mem_we    = (state_reg == PG_COPY) && (idx_reg != wcnt_reg)
                      && !sece_prot(bp_reg, mem_addr);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wel_reg <= WEL_RST;
      end else if (prog_done) begin
         wel_reg <= 1'b0;
      end else if (do_wr_en) begin
         wel_reg <= 1'b1;
      end else if (do_wr_dis) begin
         wel_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prot_en_reg <= PROT_EN_RST;
         bp_reg      <= BP_RST;
      end else if (do_st_wr) begin
         prot_en_reg <= sdata_reg[ST_PROT_EN];
         bp_reg      <= sdata_reg[ST_BP_HI:ST_BP_LO];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg  <= PG_IDLE;
         busy_reg   <= 1'b0;
         stprog_reg <= 1'b0;
         timer_reg  <= TIMER_RST;
         idx_reg    <= 7'h00;
      end else begin
         if (timer_reg != TIMER_RST) begin
            timer_reg <= timer_reg - 20'h0_0001;
         end
         case (state_reg)
            PG_IDLE: begin
               if (do_write || do_st_wr) begin
                  state_reg  <= do_write ? PG_COPY : PG_WAIT;
                  busy_reg   <= 1'b1;
                  stprog_reg <= do_st_wr;
                  timer_reg  <= TIMER_W'(PROG_CYCLES - 1);
                  idx_reg    <= 7'h00;
               end
            end
            PG_COPY: begin
               if (idx_reg == wcnt_reg) begin
                  state_reg <= PG_WAIT;
               end else begin
                  idx_reg <= idx_reg + 7'h01;
               end
            end
            PG_WAIT: begin
               if (prog_done) begin
                  state_reg  <= PG_IDLE;
                  busy_reg   <= 1'b0;
                  stprog_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= PG_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_addr] <= page[idx_reg[5:0]];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_word_reg <= 8'h00;
      end else if (stprog_reg) begin
         stat_word_reg <= {STAT_ONES, busy_reg};
      end else begin
         stat_word_reg <= {prot_en_reg, 3'h0, bp_reg, wel_reg, busy_reg};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_flag <= 1'b0;
      end else begin
         busy_flag <= busy_reg;
      end
   end

   wel_clear_a: assert property (@(posedge clk) disable iff (rst)
      $fell(busy_reg) |-> !wel_reg) else $error("latch not cleared after cycle");
   busy_hold_a: assert property (@(posedge clk) disable iff (rst)
      busy_reg && (timer_reg != TIMER_RST) |=> busy_reg) else $error("busy dropped early");
   sr_guard_a: assert property (@(posedge clk) disable iff (rst)
      end_frame && hw_prot |=> $stable(prot_en_reg) && $stable(bp_reg))
      else $error("status changed while protected");
   latch_set_a: assert property (@(posedge clk) disable iff (rst)
      do_wr_en |=> wel_reg) else $error("latch not set");
   start_edge_a: assert property (@(posedge clk) disable iff (rst)
      end_frame && (bit_cnt_reg != 3'h0) && !busy_reg |=> !busy_reg)
      else $error("cycle started on partial byte");
   block_prot_a: assert property (@(posedge clk) disable iff (rst)
      mem_we |-> (bp_reg == 2'h0) || ((bp_reg == 2'h1) && (mem_addr < PROT_QTR))
         || ((bp_reg == 2'h2) && (mem_addr < PROT_HALF))) else $error("protected byte written");
   stprog_ones_a: assert property (@(posedge clk) disable iff (rst)
      stprog_reg |=> (stat_word_reg[7:1] == STAT_ONES) && stat_word_reg[0])
      else $error("status view wrong while programming");
   addr_wrap_a: assert property (@(posedge sck) disable iff (rst)
      data_inc && (addr_reg == ADDR_TOP) |=> addr_reg == 15'h0000)
      else $error("address did not wrap");
   page_max_a: assert property (@(posedge sck) disable iff (rst)
      wcnt_reg <= PAGE_BYTES) else $error("page count overflow");

   write_cyc_c: cover property (@(posedge clk) disable iff (rst) do_write);
   stat_wr_c: cover property (@(posedge clk) disable iff (rst) do_st_wr);
   wrap_c: cover property (@(posedge sck) disable iff (rst)
      data_inc && (addr_reg == ADDR_TOP));
   rd_out_c: cover property (@(negedge sck) disable iff (rst) $rose(so_oe));

endmodule // sece_engine

// ### tb/sece_spi_master.sv
`timescale 1ns/10ps
module sece_spi_master (
   input  wire logic clk,
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // mode 0: sck rests low and only runs inside a frame
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   task automatic begin_frame();
      @(posedge clk);
      cs_n <= 1'b0;
      #1.7;
   endtask

   // si moves while sck is low, so is taken at the rise after its launching fall
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         si <= tx[i];
         #3 sck = 1'b1;
         rx[i] = so;
         #3 sck = 1'b0;
      end
   endtask

   // the gap after deselect lets the clk domain see the rise before the next frame
   task automatic end_frame();
      #3;
      @(posedge clk);
      cs_n <= 1'b1;
      si   <= ~si;
      repeat (8) @(posedge clk);
   endtask
endmodule // sece_spi_master

// ### tb/sece_engine_tb.sv
`timescale 1ns/10ps
module sece_engine_tb
   import sece_pkg::*;
;
   logic       clk;
   logic       rst;
   logic       wp_n;
   logic       sck;
   logic       cs_n;
   logic       si;
   logic       so;
   logic       so_oe;
   logic       busy_flag;
   logic [7:0] rx;
   logic [7:0] st;
   int         n_fail;
   int         total_checks;

   always #5 clk = ~clk;

   // short programming time keeps the polling loops brief
   sece_engine #(.PROG_CYCLES(40)) sece_engine_i (
      .clk       (clk),
      .rst       (rst),
      .sck       (sck),
      .cs_n      (cs_n),
      .si        (si),
      .wp_n      (wp_n),
      .so        (so),
      .so_oe     (so_oe),
      .busy_flag (busy_flag)
   );

   sece_spi_master sece_spi_master_i (
      .clk  (clk),
      .sck  (sck),
      .cs_n (cs_n),
      .si   (si),
      .so   (so)
   );

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] opc);
      sece_spi_master_i.begin_frame();
      sece_spi_master_i.xfer(opc, 8, rx);
      sece_spi_master_i.end_frame();
   endtask

   task automatic status(output logic [7:0] s);
      sece_spi_master_i.begin_frame();
      sece_spi_master_i.xfer(OPC_ST_RD, 8, rx);
      sece_spi_master_i.xfer(8'h00, 8, s);
      sece_spi_master_i.end_frame();
   endtask

   task automatic stat_wr(input logic [7:0] v);
      cmd(OPC_WR_EN);
      sece_spi_master_i.begin_frame();
      sece_spi_master_i.xfer(OPC_ST_WR, 8, rx);
      sece_spi_master_i.xfer(v, 8, rx);
      sece_spi_master_i.end_frame();
   endtask

   task automatic wait_idle();
      logic [7:0] s;
      for (int i = 0; i < 40; i++) begin
         status(s);
         if (s[ST_BUSY] === 1'b0) begin
            return;
         end
      end
      n_fail++;
      $display("Error at %0t: busy never cleared", $time);
      complete_run();
   endtask

   // writes two bytes; nbits below 8 cuts the last byte short
   task automatic mem_wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1,
                         input int nbits);
      cmd(OPC_WR_EN);
      sece_spi_master_i.begin_frame();
      sece_spi_master_i.xfer(OPC_WRITE, 8, rx);
      sece_spi_master_i.xfer(a[15:8], 8, rx);
      sece_spi_master_i.xfer(a[7:0], 8, rx);
      sece_spi_master_i.xfer(d0, 8, rx);
      sece_spi_master_i.xfer(d1, nbits, rx);
      sece_spi_master_i.end_frame();
   endtask

   task automatic prog_ok(input string what);
      chk({7'h00, busy_flag}, 8'h01, what);
      status(st);
      chk(st & 8'h01, 8'h01, what);
      wait_idle();
   endtask

   task automatic mem_rd(input logic [15:0] a, input logic [7:0] e [4], input int n);
      logic [7:0] d;
      sece_spi_master_i.begin_frame();
      sece_spi_master_i.xfer(OPC_READ, 8, rx);
      sece_spi_master_i.xfer(a[15:8], 8, rx);
      sece_spi_master_i.xfer(a[7:0], 8, rx);
      for (int i = 0; i < n; i++) begin
         sece_spi_master_i.xfer(8'h00, 8, d);
         chk(d, e[i], "read byte");
      end
      chk({7'h00, so_oe}, 8'h01, "so driven");
      sece_spi_master_i.end_frame();
      chk({7'h00, so_oe}, 8'h00, "so released");
   endtask

   initial begin
      clk          = 1'b0;
      rst          = 1'b1;
      wp_n         = 1'b1;
      n_fail       = 0;
      total_checks = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      status(st);
      chk(st, 8'h00, "status after reset");
      cmd(OPC_WR_EN);
      status(st);
      chk(st, 8'h02, "latch set");
      cmd(OPC_WR_DIS);
      status(st);
      chk(st, 8'h00, "latch cleared");
      $display("test latch done");
      mem_wr(16'h0000, 8'h11, 8'h22, 8);
      prog_ok("write low");
      status(st);
      chk(st, 8'h00, "latch after cycle");
      mem_wr(16'hfffe, 8'ha5, 8'h3c, 8);
      prog_ok("write top");
      mem_wr(16'h5fff, 8'h01, 8'h02, 8);
      prog_ok("write mid");
      mem_rd(16'hfffe, '{8'ha5, 8'h3c, 8'h11, 8'h22}, 4);
      $display("test write read done");
      mem_wr(16'h0000, 8'h55, 8'h66, 5);
      chk({7'h00, busy_flag}, 8'h00, "short byte");
      cmd(OPC_WR_DIS);
      mem_rd(16'h0000, '{8'h11, 8'h22, 8'h00, 8'h00}, 2);
      $display("test short byte done");
      stat_wr(8'hff);
      chk({7'h00, busy_flag}, 8'h01, "status prog");
      status(st);
      chk(st, 8'hff, "status during prog");
      wait_idle();
      status(st);
      chk(st, 8'h8c, "status written");
      mem_wr(16'h0000, 8'h99, 8'h98, 8);
      wait_idle();
      mem_rd(16'h0000, '{8'h11, 8'h22, 8'h00, 8'h00}, 2);
      $display("test status write done");
      wp_n <= 1'b0;
      stat_wr(8'h00);
      chk({7'h00, busy_flag}, 8'h00, "refused status");
      status(st);
      chk(st & 8'hfd, 8'h8c, "status kept");
      wp_n <= 1'b1;
      cmd(OPC_WR_DIS);
      stat_wr(8'h04);
      wait_idle();
      status(st);
      chk(st, 8'h04, "quarter protect");
      mem_wr(16'h5fff, 8'h77, 8'h88, 8);
      wait_idle();
      mem_rd(16'h5fff, '{8'h77, 8'h02, 8'h00, 8'h00}, 2);
      $display("test protection done");
      complete_run();
   end
endmodule // sece_engine_tb
